/* File: hdl/crf_map.vh */
`ifndef CRF_MAP_VH
`define CRF_MAP_VH

// byte offsets
`define CRF_OFF_ILS 8'h58
`define CRF_OFF_ILE 8'h5c
`define CRF_OFF_UNLOCK 8'h7c
`define CRF_OFF_GFC 8'h80
`define CRF_OFF_SIDFC 8'h84
`define CRF_OFF_XIDFC 8'h88
`define CRF_OFF_XIDAM 8'h90
`define CRF_OFF_HPMS 8'h94
`define CRF_OFF_NDAT1 8'h98
`define CRF_OFF_NDAT2 8'h9c

// field positions, verilog bit = 31 - printed bit
`define CRF_ILS_ROUTE 5:0
`define CRF_ILE_LINE1 1
`define CRF_ILE_LINE0 0
`define CRF_GFC_FIELD 5:0
`define CRF_GFC_STD_NONMATCH 5:4
`define CRF_GFC_EXT_NONMATCH 3:2
`define CRF_GFC_STD_REMOTE 1
`define CRF_GFC_EXT_REMOTE 0
`define CRF_SID_COUNT 23:16
`define CRF_XID_COUNT 22:16
`define CRF_LIST_BASE 15:2
`define CRF_XIDAM_MASK 28:0
`define CRF_HPMS_LIST 15
`define CRF_HPMS_INDEX 14:8
`define CRF_HPMS_OUTCOME 7:6
`define CRF_HPMS_ELEMENT 5:0
`define CRF_UNLOCK_BIT 0

// reset values and limits
`define CRF_RST_ZERO 32'h0000_0000
`define CRF_RST_XIDAM 29'h1fff_ffff
`define CRF_STD_MAX 8'h80
`define CRF_EXT_MAX 7'h40

// verdict codes on the acceptance output
`define CRF_VERDICT_FIFO0 2'h0
`define CRF_VERDICT_FIFO1 2'h1
`define CRF_VERDICT_REJECT 2'h2
`define CRF_VERDICT_ELEMENT 2'h3

`endif

/* File: hdl/crf_fresh_bank.v */
`include "crf_map.vh"
`default_nettype none

module crf_fresh_bank (
  input wire core_clk,
  input wire rst_n,
  input wire [31:0] set_vec,
  input wire [31:0] clr_vec,
  output reg [31:0] flags_q
);

  wire [31:0] flags_d;

  // a set in the clearing cycle survives
  assign flags_d = (flags_q & ~clr_vec) | set_vec;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `CRF_RST_ZERO;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/crf_accept.v */
`include "crf_map.vh"
`default_nettype none

module crf_accept (
  input wire core_clk,
  input wire rst_n,
  input wire rx_valid,
  input wire rx_ext,
  input wire rx_remote,
  input wire rx_hit,
  input wire [28:0] rx_id,
  input wire [28:0] ext_mask,
  input wire [5:0] gfc,
  input wire std_enabled,
  input wire ext_enabled,
  output reg [28:0] cmp_id_q,
  output reg verdict_valid_q,
  output reg [1:0] verdict_q
);

  reg [1:0] nonmatch;
  reg remote_rej;
  reg list_on;
  reg [1:0] verdict_d;

  always @* begin
    nonmatch = rx_ext ? gfc[`CRF_GFC_EXT_NONMATCH] : gfc[`CRF_GFC_STD_NONMATCH];
    remote_rej = rx_remote & (rx_ext ? gfc[`CRF_GFC_EXT_REMOTE] : gfc[`CRF_GFC_STD_REMOTE]);
    list_on = rx_ext ? ext_enabled : std_enabled;
    if (remote_rej) begin
      verdict_d = `CRF_VERDICT_REJECT;
    end else if (rx_hit && list_on) begin
      verdict_d = `CRF_VERDICT_ELEMENT;
    end else if (nonmatch[1]) begin
      verdict_d = `CRF_VERDICT_REJECT;
    end else begin
      verdict_d = {1'b0, nonmatch[0]};
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_id_q <= 29'h0;
      verdict_valid_q <= 1'b0;
      verdict_q <= `CRF_VERDICT_FIFO0;
    end else begin
      // the comparator downstream sees the masked id, standard ids pass bare
      cmp_id_q <= rx_ext ? (rx_id & ext_mask) : {18'h0, rx_id[10:0]};
      verdict_valid_q <= rx_valid;
      if (rx_valid) begin
        verdict_q <= verdict_d;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdl/crf_regs.v */
// The Avalon-MM slave port was decided locally.
`include "crf_map.vh"
`default_nettype none

// Contract
// - six fifo flags routed by select bits
// - line enables gate each output line
// - standard non-match: fifo0, fifo1 or reject
// - extended non-match: fifo0, fifo1 or reject
// - remote reject bits override filtering
// - filter config writes need unlock; the extended id mask takes writes while locked
// - standard count clamps at 128
// - standard list base is word address
// - extended count clamps at 64
// - extended list base is word address
// - mask ANDed with extended id
// - mask resets to all ones
// - priority status updates on priority match
// - report list and element index
// - reported index stays below list count
// - storage outcome code in two bits
// - fifo element index valid when outcome high
// - buffers 0 to 31 set low flags
// - buffers 32 to 63 set high flags
// - flags clear on written one only
// - flags clear on hard reset
// - reserved bits read zero, ignore writes
module crf_regs (
  input wire core_clk,
  input wire rst_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [5:0] int_flags,
  input wire [5:0] int_enables,
  output reg irq_line0,
  output reg irq_line1,
  input wire rx_valid,
  input wire rx_ext,
  input wire rx_remote,
  input wire rx_hit,
  input wire [28:0] rx_id,
  output wire [28:0] cmp_id,
  output wire verdict_valid,
  output wire [1:0] verdict,
  output reg [7:0] std_filter_count,
  output reg [13:0] std_filter_base,
  output reg [6:0] ext_filter_count,
  output reg [13:0] ext_filter_base,
  input wire prio_valid,
  input wire prio_ext,
  input wire [6:0] prio_index,
  input wire [1:0] prio_outcome,
  input wire [5:0] prio_element,
  input wire buf_update,
  input wire [5:0] buf_index
);

  reg [5:0] ils_q;
  reg [1:0] ile_q;
  reg unlock_q;
  reg [5:0] gfc_q;
  reg [7:0] std_count_q;
  reg [13:0] std_base_q;
  reg [6:0] ext_count_q;
  reg [13:0] ext_base_q;
  reg [28:0] xidam_q;
  reg [15:0] hpms_q;
  reg [31:0] rd_d;
  reg prio_ok;
  wire [31:0] fresh_lo;
  wire [31:0] fresh_hi;
  wire [31:0] set_lo;
  wire [31:0] set_hi;
  wire [31:0] clr_lo;
  wire [31:0] clr_hi;
  wire [31:0] wm;
  wire [31:0] wd;
  wire [7:0] byte_addr;
  wire req;
  wire commit;
  wire wr_en;
  wire prot_ok;

  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function wr_at;
    input [7:0] addr;
    input [7:0] off;
    input en;
    begin
      wr_at = en && (addr == off);
    end
  endfunction

  // the engine never sees more elements than the list can hold
  function [7:0] clamp_std;
    input [7:0] count;
    begin
      clamp_std = (count > `CRF_STD_MAX) ? `CRF_STD_MAX : count;
    end
  endfunction

  function [6:0] clamp_ext;
    input [6:0] count;
    begin
      clamp_ext = (count > `CRF_EXT_MAX) ? `CRF_EXT_MAX : count;
    end
  endfunction

  assign byte_addr = {avs_address, 2'b00};
  assign wm = lane_mask(avs_byteenable);
  assign wd = avs_writedata & wm;

  // waitrequest idles high; each access costs one wait cycle so that read data
  // come from a flop and writes land on the single edge the master sees low
  assign req = avs_read | avs_write;
  assign commit = req & ~avs_waitrequest;
  assign wr_en = commit & avs_write;
  assign prot_ok = wr_en & unlock_q;

  localparam BUS_WAIT = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  reg bus_state_q;
  reg bus_state_d;

  // the answer state always falls back, so a dropped request cannot leave waitrequest low
  always @* begin
    case (bus_state_q)
      BUS_WAIT: begin
        bus_state_d = req ? BUS_ANSWER : BUS_WAIT;
      end
      BUS_ANSWER: begin
        bus_state_d = BUS_WAIT;
      end
      default: begin
        bus_state_d = BUS_WAIT;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_q <= BUS_WAIT;
      avs_waitrequest <= 1'b1;
      avs_readdata <= `CRF_RST_ZERO;
    end else begin
      bus_state_q <= bus_state_d;
      avs_waitrequest <= (bus_state_d != BUS_ANSWER);
      // readdata holds until the next read; writes leave it alone
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_d;
      end
    end
  end

  always @* begin
    case (byte_addr)
      `CRF_OFF_ILS: begin
        rd_d = {26'h0, ils_q};
      end
      `CRF_OFF_ILE: begin
        rd_d = {30'h0, ile_q};
      end
      `CRF_OFF_UNLOCK: begin
        rd_d = {31'h0, unlock_q};
      end
      `CRF_OFF_GFC: begin
        rd_d = {26'h0, gfc_q};
      end
      `CRF_OFF_SIDFC: begin
        rd_d = {8'h0, std_count_q, std_base_q, 2'h0};
      end
      `CRF_OFF_XIDFC: begin
        rd_d = {9'h0, ext_count_q, ext_base_q, 2'h0};
      end
      `CRF_OFF_XIDAM: begin
        rd_d = {3'h0, xidam_q};
      end
      `CRF_OFF_HPMS: begin
        rd_d = {16'h0, hpms_q};
      end
      `CRF_OFF_NDAT1: begin
        rd_d = fresh_lo;
      end
      `CRF_OFF_NDAT2: begin
        rd_d = fresh_hi;
      end
      default: begin
        rd_d = `CRF_RST_ZERO;
      end
    endcase
  end

  // line select, line enable and unlock take any write
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ils_q <= 6'h0;
      ile_q <= 2'h0;
      unlock_q <= 1'b0;
    end else begin
      if (wr_at(byte_addr, `CRF_OFF_ILS, wr_en)) begin
        ils_q <= (ils_q & ~wm[`CRF_ILS_ROUTE]) | wd[`CRF_ILS_ROUTE];
      end
      if (wr_at(byte_addr, `CRF_OFF_ILE, wr_en)) begin
        ile_q <= (ile_q & ~wm[1:0]) | wd[1:0];
      end
      if (wr_at(byte_addr, `CRF_OFF_UNLOCK, wr_en)) begin
        unlock_q <= (unlock_q & ~wm[`CRF_UNLOCK_BIT]) | wd[`CRF_UNLOCK_BIT];
      end
    end
  end

  // filter setup is only writable while unlocked; locked writes vanish silently
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gfc_q <= 6'h0;
      std_count_q <= 8'h0;
      std_base_q <= 14'h0;
      ext_count_q <= 7'h0;
      ext_base_q <= 14'h0;
    end else begin
      if (wr_at(byte_addr, `CRF_OFF_GFC, prot_ok)) begin
        gfc_q <= (gfc_q & ~wm[`CRF_GFC_FIELD]) | wd[`CRF_GFC_FIELD];
      end
      if (wr_at(byte_addr, `CRF_OFF_SIDFC, prot_ok)) begin
        std_count_q <= (std_count_q & ~wm[`CRF_SID_COUNT]) | wd[`CRF_SID_COUNT];
        std_base_q <= (std_base_q & ~wm[`CRF_LIST_BASE]) | wd[`CRF_LIST_BASE];
      end
      if (wr_at(byte_addr, `CRF_OFF_XIDFC, prot_ok)) begin
        ext_count_q <= (ext_count_q & ~wm[`CRF_XID_COUNT]) | wd[`CRF_XID_COUNT];
        ext_base_q <= (ext_base_q & ~wm[`CRF_LIST_BASE]) | wd[`CRF_LIST_BASE];
      end
    end
  end

  // the mask is not a protected field
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xidam_q <= `CRF_RST_XIDAM;
    end else if (wr_at(byte_addr, `CRF_OFF_XIDAM, wr_en)) begin
      xidam_q <= (xidam_q & ~wm[`CRF_XIDAM_MASK]) | wd[`CRF_XIDAM_MASK];
    end
  end

  // readback keeps the written count; the filter engine sees the clamped one
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      std_filter_count <= 8'h0;
      ext_filter_count <= 7'h0;
      std_filter_base <= 14'h0;
      ext_filter_base <= 14'h0;
    end else begin
      std_filter_count <= clamp_std(std_count_q);
      ext_filter_count <= clamp_ext(ext_count_q);
      std_filter_base <= std_base_q;
      ext_filter_base <= ext_base_q;
    end
  end

  crf_accept u_accept (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_ext(rx_ext),
    .rx_remote(rx_remote),
    .rx_hit(rx_hit),
    .rx_id(rx_id),
    .ext_mask(xidam_q),
    .gfc(gfc_q),
    .std_enabled(std_filter_count != 8'h0),
    .ext_enabled(ext_filter_count != 7'h0),
    .cmp_id_q(cmp_id),
    .verdict_valid_q(verdict_valid),
    .verdict_q(verdict)
  );

  // an index at or past the list length cannot be a real element, so it is dropped
  always @* begin
    if (prio_ext) begin
      prio_ok = prio_index < ext_filter_count;
    end else begin
      prio_ok = {1'b0, prio_index} < std_filter_count;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hpms_q <= 16'h0;
    end else if (prio_valid && prio_ok) begin
      hpms_q[`CRF_HPMS_LIST] <= prio_ext;
      hpms_q[`CRF_HPMS_INDEX] <= prio_index;
      hpms_q[`CRF_HPMS_OUTCOME] <= prio_outcome;
      hpms_q[`CRF_HPMS_ELEMENT] <= prio_outcome[1] ? prio_element : 6'h0;
    end
  end

  // buffer n sits at printed bit n mod 32 of its register, which is verilog bit 31-(n mod 32)
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_set
      assign set_lo[31 - gi] = buf_update & (buf_index == gi);
      assign set_hi[31 - gi] = buf_update & (buf_index == (gi + 32));
    end
  endgenerate

  assign clr_lo = wr_at(byte_addr, `CRF_OFF_NDAT1, wr_en) ? wd : `CRF_RST_ZERO;
  assign clr_hi = wr_at(byte_addr, `CRF_OFF_NDAT2, wr_en) ? wd : `CRF_RST_ZERO;

  crf_fresh_bank u_fresh_lo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_vec(set_lo),
    .clr_vec(clr_lo),
    .flags_q(fresh_lo)
  );

  crf_fresh_bank u_fresh_hi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_vec(set_hi),
    .clr_vec(clr_hi),
    .flags_q(fresh_hi)
  );

  // a flag cleared in the routing bit goes to line 0
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_line0 <= 1'b0;
      irq_line1 <= 1'b0;
    end else begin
      irq_line0 <= ile_q[`CRF_ILE_LINE0] & (|(int_flags & int_enables & ~ils_q));
      irq_line1 <= ile_q[`CRF_ILE_LINE1] & (|(int_flags & int_enables & ils_q));
    end
  end

endmodule

`default_nettype wire

/* File: tb/crf_checker.sv */
`default_nettype none
module crf_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [5:0] int_flags,
  input wire logic [5:0] int_enables,
  input wire logic irq_line0,
  input wire logic irq_line1,
  input wire logic rx_valid,
  input wire logic rx_ext,
  input wire logic rx_remote,
  input wire logic rx_hit,
  input wire logic [28:0] rx_id,
  input wire logic [28:0] cmp_id,
  input wire logic verdict_valid,
  input wire logic [1:0] verdict,
  input wire logic [7:0] std_filter_count,
  input wire logic [6:0] ext_filter_count
);
  timeunit 1ns;
  timeprecision 1ns;
  wire hit_ok = rx_valid && rx_hit && !rx_remote && (rx_ext ? |ext_filter_count : |std_filter_count);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ack)
    else $error("bus answer not one wait");
  AST_VERDICT_PULSE: assert property (rx_valid |=> verdict_valid)
    else $error("verdict missing");
  AST_VERDICT_HOLD: assert property (!rx_valid |=> !verdict_valid && $stable(verdict))
    else $error("verdict moved");
  AST_HIT_ELEMENT: assert property (hit_ok |=> verdict == 2'h3)
    else $error("hit not sent to element");
  AST_STD_ID: assert property (rx_valid && !rx_ext |=> cmp_id == ($past(rx_id) & 29'h7ff))
    else $error("standard id compare value");
  AST_STD_CLAMP: assert property (std_filter_count <= 8'h80)
    else $error("standard count above limit");
  AST_EXT_CLAMP: assert property (ext_filter_count <= 7'h40)
    else $error("extended count above limit");
  AST_IRQ_QUIET: assert property ((int_flags & int_enables) == 6'h0 |=> !irq_line0 && !irq_line1)
    else $error("line raised without flag");
endmodule
`default_nettype wire

/* File: tb/crf_frame_src.sv */
`default_nettype none
module crf_frame_src (
  input wire logic core_clk,
  output var logic rx_valid,
  output var logic rx_ext,
  output var logic rx_remote,
  output var logic rx_hit,
  output var logic [28:0] rx_id,
  output var logic prio_valid,
  output var logic prio_ext,
  output var logic [6:0] prio_index,
  output var logic [1:0] prio_outcome,
  output var logic [5:0] prio_element,
  output var logic buf_update,
  output var logic [5:0] buf_index
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {rx_valid, rx_ext, rx_remote, rx_hit, rx_id} = '0;
    {prio_valid, prio_ext, prio_index, prio_outcome, prio_element} = '0;
    {buf_update, buf_index} = '0;
  end
  // idle fields go inverted so a stale value never passes for a fresh one
  task automatic frm(input logic e, r, h, input logic [28:0] id);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    {rx_ext, rx_remote, rx_hit, rx_id} <= {e, r, h, id};
    @(posedge core_clk);
    rx_valid <= 1'b0;
    {rx_ext, rx_remote, rx_hit, rx_id} <= ~{e, r, h, id};
  endtask
  task automatic pri(input logic e, input logic [6:0] i, input logic [1:0] o, input logic [5:0] el);
    @(posedge core_clk);
    prio_valid <= 1'b1;
    {prio_ext, prio_index, prio_outcome, prio_element} <= {e, i, o, el};
    @(posedge core_clk);
    prio_valid <= 1'b0;
    {prio_ext, prio_index, prio_outcome, prio_element} <= ~{e, i, o, el};
  endtask
  task automatic bup(input logic [5:0] i);
    @(posedge core_clk);
    buf_update <= 1'b1;
    buf_index <= i;
    @(posedge core_clk);
    buf_update <= 1'b0;
    buf_index <= ~i;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`include "crf_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, avs_read, avs_write;
  logic [5:0] avs_address, int_flags, int_enables;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq_line0, irq_line1, rx_valid, rx_ext, rx_remote, rx_hit, verdict_valid;
  wire prio_valid, prio_ext, buf_update;
  wire [28:0] rx_id, cmp_id;
  wire [1:0] verdict, prio_outcome;
  wire [7:0] std_filter_count;
  wire [6:0] ext_filter_count, prio_index;
  wire [13:0] std_filter_base, ext_filter_base;
  wire [5:0] prio_element, buf_index;
  int n_errors, tests_run;
  crf_regs u_crf_regs (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .int_flags, .int_enables, .irq_line0,
    .irq_line1, .rx_valid, .rx_ext, .rx_remote, .rx_hit, .rx_id, .cmp_id, .verdict_valid, .verdict,
    .std_filter_count, .std_filter_base, .ext_filter_count, .ext_filter_base, .prio_valid,
    .prio_ext, .prio_index, .prio_outcome, .prio_element, .buf_update, .buf_index);
  crf_frame_src u_crf_frame_src (.core_clk, .rx_valid, .rx_ext, .rx_remote, .rx_hit, .rx_id,
    .prio_valid, .prio_ext, .prio_index, .prio_outcome, .prio_element, .buf_update, .buf_index);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge core_clk);
    avs_address <= a[7:2];
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 20) begin
      n_errors++;
      give_verdict;
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic fr(input logic e, r, h, input logic [28:0] id, input logic [1:0] ex);
    u_crf_frame_src.frm(e, r, h, id);
    @(negedge core_clk);
    chk("verdict_valid", 32'h1, {31'h0, verdict_valid});
    chk("verdict", {30'h0, ex}, {30'h0, verdict});
  endtask
  task automatic ir(input logic e0, e1);
    repeat (2) @(negedge core_clk);
    chk("irq_line0", {31'h0, e0}, {31'h0, irq_line0});
    chk("irq_line1", {31'h0, e1}, {31'h0, irq_line1});
  endtask
  task automatic t_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(`CRF_OFF_XIDAM, 32'h1fff_ffff, "mask reset");
    rc(`CRF_OFF_NDAT1, 32'h0, "fresh low reset");
    rc(`CRF_OFF_NDAT2, 32'h0, "fresh high reset");
  endtask
  task automatic t_cfg;
    w(`CRF_OFF_GFC, 32'hffff_ffff);
    rc(`CRF_OFF_GFC, 32'h0, "locked gfc");
    w(`CRF_OFF_UNLOCK, 32'h1);
    w(`CRF_OFF_GFC, 32'hffff_ffff);
    rc(`CRF_OFF_GFC, 32'h3f, "gfc");
    w(`CRF_OFF_SIDFC, 32'hffff_ffff);
    w(`CRF_OFF_XIDFC, 32'hffff_ffff);
    w(8'h40, 32'hffff_ffff);
    rc(`CRF_OFF_SIDFC, 32'h00ff_fffc, "sidfc");
    rc(`CRF_OFF_XIDFC, 32'h007f_fffc, "xidfc");
    rc(8'h40, 32'h0, "unmapped");
    chk("std count", 32'h80, {24'h0, std_filter_count});
    chk("std base", 32'h3fff, {18'h0, std_filter_base});
    chk("ext count", 32'h40, {25'h0, ext_filter_count});
    chk("ext base", 32'h3fff, {18'h0, ext_filter_base});
  endtask
  task automatic t_filt;
    for (int c = 0; c < 4; c++) begin
      w(`CRF_OFF_GFC, 32'(c) << 4);
      fr(1'b0, 1'b0, 1'b0, 29'h7ff, (c < 2) ? c[1:0] : 2'h2);
      w(`CRF_OFF_GFC, 32'(c) << 2);
      fr(1'b1, 1'b0, 1'b0, 29'h1fff_ffff, (c < 2) ? c[1:0] : 2'h2);
    end
    for (int c = 0; c < 2; c++) begin
      w(`CRF_OFF_GFC, 32'h1 << c);
      fr(1'b1, 1'b1, 1'b1, 29'h155, c ? 2'h3 : 2'h2);
      fr(1'b0, 1'b1, 1'b1, 29'h2aa, c ? 2'h2 : 2'h3);
    end
    w(`CRF_OFF_GFC, 32'h10);
    fr(1'b0, 1'b0, 1'b1, 29'h7f, 2'h3);
    w(`CRF_OFF_SIDFC, 32'h0);
    fr(1'b0, 1'b0, 1'b1, 29'h7f, 2'h1);
    w(`CRF_OFF_XIDAM, 32'hffff_ff00);
    rc(`CRF_OFF_XIDAM, 32'h1fff_ff00, "mask");
    fr(1'b1, 1'b0, 1'b0, 29'h1234_5678, 2'h0);
    chk("cmp_id", 32'h1234_5600, {3'h0, cmp_id});
    @(posedge core_clk);
    avs_byteenable <= 4'h2;
    w(`CRF_OFF_XIDAM, 32'h0);
    avs_byteenable <= 4'hf;
    rc(`CRF_OFF_XIDAM, 32'h1fff_0000, "mask lane");
  endtask
  task automatic t_prio;
    w(`CRF_OFF_SIDFC, 32'h0005_0000);
    w(`CRF_OFF_XIDFC, 32'h0003_0000);
    u_crf_frame_src.pri(1'b0, 7'h4, 2'h3, 6'h2a);
    rc(`CRF_OFF_HPMS, 32'h0000_04ea, "prio std");
    u_crf_frame_src.pri(1'b0, 7'h5, 2'h2, 6'h01);
    rc(`CRF_OFF_HPMS, 32'h0000_04ea, "prio over count");
    u_crf_frame_src.pri(1'b1, 7'h2, 2'h1, 6'h3f);
    rc(`CRF_OFF_HPMS, 32'h0000_8240, "prio lost");
    u_crf_frame_src.pri(1'b1, 7'h0, 2'h2, 6'h11);
    rc(`CRF_OFF_HPMS, 32'h0000_8091, "prio fifo0");
  endtask
  task automatic t_fresh;
    u_crf_frame_src.bup(6'd0);
    u_crf_frame_src.bup(6'd63);
    u_crf_frame_src.bup(6'd33);
    rc(`CRF_OFF_NDAT1, 32'h8000_0000, "fresh low");
    rc(`CRF_OFF_NDAT2, 32'h4000_0001, "fresh high");
    w(`CRF_OFF_NDAT2, 32'h0);
    rc(`CRF_OFF_NDAT2, 32'h4000_0001, "fresh kept");
    w(`CRF_OFF_NDAT2, 32'h4000_0000);
    rc(`CRF_OFF_NDAT2, 32'h1, "fresh cleared");
  endtask
  task automatic t_irq;
    w(`CRF_OFF_ILE, 32'hffff_ffff);
    rc(`CRF_OFF_ILE, 32'h3, "line enable");
    for (int b = 0; b < 6; b++) begin
      @(posedge core_clk);
      int_flags <= 6'h1 << b;
      int_enables <= 6'h3f;
      w(`CRF_OFF_ILS, 32'h0);
      ir(1'b1, 1'b0);
      w(`CRF_OFF_ILS, 32'h1 << b);
      ir(1'b0, 1'b1);
    end
    w(`CRF_OFF_ILE, 32'h1);
    ir(1'b0, 1'b0);
    w(`CRF_OFF_ILS, 32'h0);
    ir(1'b1, 1'b0);
    @(posedge core_clk);
    int_enables <= 6'h1f;
    ir(1'b0, 1'b0);
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {avs_read, avs_write, int_flags, int_enables, avs_address, avs_writedata} = '0;
    t_reset;
    t_cfg;
    t_filt;
    t_prio;
    t_fresh;
    t_reset;
    t_irq;
    give_verdict;
  end
endmodule
bind crf_regs crf_checker u_crf_checker (.core_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .int_flags, .int_enables, .irq_line0, .irq_line1, .rx_valid, .rx_ext, .rx_remote, .rx_hit, .rx_id,
  .cmp_id, .verdict_valid, .verdict, .std_filter_count, .ext_filter_count);
`default_nettype wire
